// ---- verilog/adc_link_pkg.sv ----
// Shared constants for the serial converter link and both of its ends
package adc_link_pkg;
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int LEAD_ZEROS = 3;
    localparam logic [4:0] EDGE_GUARD = 5'h02;
    localparam logic [4:0] EDGE_KEEP = 5'h0A;
    localparam logic [4:0] EDGE_FULL = 5'h10;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 40;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
    localparam int QUIET_NS = 400;
    localparam int QUIET_CYC = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_PTR_BITS = 1;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_SETUP = 2'b01,
        HOST_CLOCK = 2'b10,
        HOST_QUIET = 2'b11
    } host_state_t;
endpackage : adc_link_pkg

// ---- verilog/adc_link_if.sv ----
// Three-wire link between the converter and its host
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
    logic frame_select_n;
    logic sclk;
    logic serial_out_d;
    logic serial_out_oe;
    wire serial_out_line;

    // Floated line shows the opposite of the last driven bit
    assign serial_out_line = serial_out_oe ? serial_out_d : !serial_out_d;

    modport dev (
        input frame_select_n,
        input sclk,
        output serial_out_d,
        output serial_out_oe
    );
    modport host (
        output frame_select_n,
        output sclk,
        input serial_out_line
    );
endinterface : adc_link_if
`default_nettype wire

// ---- verilog/adc_conv_dev.sv ----
// Converter end: frame edge counting, mode control and serial output
`timescale 1ns/10ps
`default_nettype none
module adc_conv_dev
    import adc_link_pkg::*;
(
    input wire logic rst_b,                     // Sync reset, active low
    adc_link_if.dev link,                       // Serial link
    input wire logic [DATA_BITS-1:0] sample_in, // Value to convert
    output logic analog_on,                     // Analog circuitry powered
    output logic shutdown_mode,                 // Device in shutdown
    output logic frame_dummy,                   // Current frame invalid
    output logic powered_up                     // Full power reached
);
    logic start_tog;
    logic seen_tog;
    logic skip_tog;
    logic cold;
    logic [DATA_BITS-1:0] held;
    logic [4:0] edge_cnt;
    logic [4:0] cnt_now;
    logic frame_new;
    logic [WORD_BITS-1:0] word;

    // Frame start marker, clocked by the select line itself
    always_ff @(negedge link.frame_select_n) begin
        if (!rst_b) begin
            start_tog <= 1'b0;
        end else begin
            start_tog <= ~start_tog;
        end
    end

    // Sample and hold at the select fall
    always_ff @(negedge link.frame_select_n) begin
        if (!rst_b) begin
            held <= '0;
            cold <= 1'b1;
            frame_dummy <= 1'b1;
        end else begin
            held <= sample_in;
            cold <= 1'b0;
            frame_dummy <= shutdown_mode | cold;
        end
    end

    // Falling serial clock edges counted from the frame start
    always_ff @(negedge link.sclk) begin
        if (!rst_b) begin
            seen_tog <= 1'b0;
            edge_cnt <= EDGE_FULL;
        end else begin
            seen_tog <= start_tog ^ skip_tog;
            if (frame_new) begin
                edge_cnt <= 5'h01;
            end else if (!link.frame_select_n && edge_cnt < EDGE_FULL) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
        end
    end

    // Full power once a kept wake frame runs sixteen cycles
    always_ff @(negedge link.sclk) begin
        if (!rst_b) begin
            powered_up <= 1'b0;
        end else if (frame_new) begin
            powered_up <= !shutdown_mode && !cold;
        end else if (edge_cnt == EDGE_FULL - 5'h01) begin
            powered_up <= 1'b1;
        end
    end

    assign frame_new = (start_tog != (seen_tog ^ skip_tog));
    assign cnt_now = frame_new ? 5'h00 : edge_cnt;

    // Mode decided from the count at the select rise
    always_ff @(posedge link.frame_select_n) begin
        if (!rst_b) begin
            shutdown_mode <= 1'b0;
        end else if (frame_dummy && !cold) begin
            shutdown_mode <= (cnt_now < EDGE_KEEP);
        end else if (cnt_now >= EDGE_KEEP) begin
            shutdown_mode <= 1'b0;
        end else if (cnt_now >= EDGE_GUARD) begin
            shutdown_mode <= 1'b1;
        end
        // Fewer than two edges in a non-dummy frame: glitch, mode held
    end

    // Frame closed with no clock edge: marker settled here
    always_ff @(posedge link.frame_select_n) begin
        if (!rst_b) begin
            skip_tog <= 1'b0;
        end else if (frame_new) begin
            skip_tog <= ~skip_tog;
        end
    end

    // Analog circuitry off in shutdown until select falls
    assign analog_on = !shutdown_mode || !link.frame_select_n;

    // Leading zeros, result MSB first, one trailing pad bit
    assign word = {{LEAD_ZEROS{1'b0}}, held, 1'b0};

    always_comb begin
        link.serial_out_d = 1'b0;
        if (cnt_now < EDGE_FULL) begin
            link.serial_out_d = word[4'hF - cnt_now[3:0]];
        end
    end

    // Driven from select fall until sixteen edges or select rise
    assign link.serial_out_oe = !link.frame_select_n
        && (cnt_now < EDGE_FULL);
endmodule : adc_conv_dev
`default_nettype wire

// ---- verilog/adc_link_host.sv ----
// Host end: frame generator, serial clock divider, word buffer
`timescale 1ns/10ps
`default_nettype none
module adc_link_host
    import adc_link_pkg::*;
(
    input wire logic clk,                       // 100 MHz system clock
    input wire logic rst_b,                     // Sync reset, active low
    adc_link_if.host link,                      // Serial link
    input wire logic cmd_valid,                 // Frame request
    output logic cmd_ready,                     // Frame request taken
    input wire logic [4:0] cmd_edges,           // Falling edges before rise
    output logic busy,                          // Frame or quiet in progress
    output logic word_valid,                    // Received word available
    input wire logic word_ready,                // Consumer takes word
    output logic [DATA_BITS-1:0] word_data      // Received result
);
    host_state_t state;
    host_state_t next_state;
    logic [7:0] timer;
    logic [4:0] edges;
    logic [4:0] target;
    logic [2:0] sync_pipe;
    logic line_in;
    logic [WORD_BITS-1:0] shreg;
    logic [DATA_BITS-1:0] buf_mem [BUF_DEPTH];
    logic [BUF_PTR_BITS-1:0] wr_ptr;
    logic [BUF_PTR_BITS-1:0] rd_ptr;
    logic [1:0] fill;
    logic buf_full;
    logic push;
    logic pop;
    logic half_done;
    logic last_edge;

    assign buf_full = (fill == 2'(BUF_DEPTH));
    assign half_done = (timer == 8'h00);
    assign last_edge = (edges >= target);
    // Buffer room stalls new frames
    assign cmd_ready = (state == HOST_IDLE) && !buf_full;
    assign busy = (state != HOST_IDLE);

    always_comb begin
        next_state = state;
        case (state)
            HOST_IDLE: begin
                if (cmd_valid && cmd_ready) begin
                    next_state = HOST_SETUP;
                end
            end
            HOST_SETUP: begin
                if (half_done) begin
                    next_state = (target == 5'h00) ? HOST_QUIET : HOST_CLOCK;
                end
            end
            HOST_CLOCK: begin
                if (half_done && link.sclk == 1'b0 && last_edge) begin
                    next_state = HOST_QUIET;
                end
            end
            HOST_QUIET: begin
                if (half_done) begin
                    next_state = HOST_IDLE;
                end
            end
            default: begin
                next_state = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= HOST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Half-period and quiet timer
    // Forty quiet cycles bound the frame rate
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timer <= 8'h00;
        end else if (next_state == HOST_QUIET && state != HOST_QUIET) begin
            timer <= 8'(QUIET_CYC - 1);
        end else if (next_state != state || half_done) begin
            timer <= 8'(SCLK_HALF_CYC - 1);
        end else begin
            timer <= timer - 8'h01;
        end
    end

    // Select low from setup until the requested edge count
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link.frame_select_n <= 1'b1;
            target <= 5'h00;
        end else if (state == HOST_IDLE && next_state == HOST_SETUP) begin
            link.frame_select_n <= 1'b0;
            target <= (cmd_edges > EDGE_FULL) ? EDGE_FULL : cmd_edges;
        end else if (next_state == HOST_QUIET) begin
            link.frame_select_n <= 1'b1;
        end
    end

    // Serial clock divided from clk, idles high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link.sclk <= 1'b1;
            edges <= 5'h00;
        end else if (state == HOST_SETUP) begin
            link.sclk <= 1'b1;
            edges <= 5'h00;
            if (half_done && target != 5'h00) begin
                link.sclk <= 1'b0;
                edges <= 5'h01;
            end
        end else if (state == HOST_CLOCK && half_done) begin
            if (link.sclk) begin
                link.sclk <= 1'b0;
                edges <= edges + 5'h01;
            end else begin
                link.sclk <= 1'b1;
            end
        end
    end

    // Pin synchroniser, three stages
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_pipe <= 3'h0;
        end else begin
            sync_pipe <= {sync_pipe[1:0], link.serial_out_line};
        end
    end

    // Line level accepted once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            line_in <= 1'b0;
        end else if (sync_pipe[2] == sync_pipe[1]) begin
            line_in <= sync_pipe[2];
        end
    end

    // Bit taken just before each falling edge the host makes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shreg <= '0;
        end else if (half_done && link.sclk
            && (state == HOST_SETUP || state == HOST_CLOCK)) begin
            shreg <= {shreg[WORD_BITS-2:0], line_in};
        end
    end

    // Only full sixteen-edge frames produce a word
    // Pushed on the first quiet cycle, once the capture is final
    assign push = (state == HOST_QUIET) && (timer == 8'(QUIET_CYC - 1))
        && (target == EDGE_FULL) && !buf_full;
    assign pop = word_valid && word_ready;
    assign word_valid = (fill != 2'h0);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill <= fill + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            buf_mem[wr_ptr] <= shreg[DATA_BITS:1];
        end
    end

    assign word_data = buf_mem[rd_ptr];
endmodule : adc_link_host
`default_nettype wire

// ---- tb/adc_link_assertions.sv ----
// Timing checks on the three-wire converter link
`timescale 1ns/10ps
`default_nettype none
module adc_link_assertions
    import adc_link_pkg::*;
(
    input wire logic clk,            // System clock
    input wire logic rst_b,          // Device reset, active low
    input wire logic frame_select_n, // Frame select
    input wire logic sclk,           // Serial clock
    input wire logic serial_out_d,   // Device data
    input wire logic serial_out_oe   // Device drive enable
);
    logic [4:0] edge_cnt;
    logic [7:0] high_cnt;

    // Falling serial edges seen in the current frame
    always_ff @(posedge clk) begin
        if (!rst_b || $fell(frame_select_n)) begin
            edge_cnt <= 5'h00;
        end else if (!frame_select_n && $fell(sclk)) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // Cycles with select high, saturating
    always_ff @(posedge clk) begin
        if (!frame_select_n) begin
            high_cnt <= 8'h00;
        end else if (high_cnt != 8'hFF) begin
            high_cnt <= high_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_low_half;
        !sclk [*4];
    endsequence

    a_drive_on_fall: assert property (
        $fell(frame_select_n) |-> serial_out_oe)
        else $error("output not driven at frame start");
    a_float_high: assert property (
        frame_select_n |-> !serial_out_oe)
        else $error("output driven with select high");
    a_drive_in_frame: assert property (
        !frame_select_n && edge_cnt < 5'h10 && !$fell(sclk) |-> serial_out_oe)
        else $error("output floated inside frame");
    a_lead_zeros: assert property (
        serial_out_oe && edge_cnt < 5'h03 && !$fell(sclk) |-> !serial_out_d)
        else $error("leading bit not zero");
    a_pad_zero: assert property (
        serial_out_oe && edge_cnt == 5'h0F && !$fell(sclk) |-> !serial_out_d)
        else $error("pad bit not zero");
    a_float_full: assert property (
        edge_cnt == 5'h10 && !$fell(frame_select_n) |-> !serial_out_oe)
        else $error("output driven after full word");
    a_edge_limit: assert property (
        edge_cnt <= 5'h10)
        else $error("more than sixteen edges in frame");
    a_sclk_half: assert property (
        $fell(sclk) |-> s_low_half)
        else $error("serial clock low half too short");
    a_quiet_gap: assert property (
        $fell(frame_select_n) |-> high_cnt >= QUIET_CYC - 1)
        else $error("select fell before quiet interval");
endmodule : adc_link_assertions
`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench: host and converter ends joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import adc_link_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic dev_rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    logic word_ready = 1'b0;
    logic [4:0] cmd_edges = 5'h00;
    logic [DATA_BITS-1:0] sample_in = 12'h000;
    logic cmd_ready, busy, word_valid, analog_on, shutdown_mode;
    logic frame_dummy, powered_up;
    logic [DATA_BITS-1:0] word_data;
    logic [DATA_BITS-1:0] pend[$];
    int miscompares = 0;
    int samples_checked = 0;
    logic [4:0] t_edges [12] = '{5'h10, 5'h10, 5'h01, 5'h0C, 5'h02, 5'h01,
        5'h09, 5'h0A, 5'h09, 5'h10, 5'h10, 5'h14};
    localparam logic [11:0] sd_mask = 12'h170;
    localparam logic [11:0] dm_mask = 12'h2E1;
    localparam logic [11:0] rd_mask = 12'h203;
    localparam logic [11:0] keep_mask = 12'hC00;

    always #5 clk = ~clk;

    adc_link_if link();
    adc_link_host adc_link_host_i(.clk(clk), .rst_b(rst_b), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_edges(cmd_edges), .busy(busy), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data));
    adc_conv_dev adc_conv_dev_i(.rst_b(dev_rst_b), .link(link),
        .sample_in(sample_in), .analog_on(analog_on),
        .shutdown_mode(shutdown_mode), .frame_dummy(frame_dummy),
        .powered_up(powered_up));
    adc_link_assertions adc_link_assertions_i(.clk(clk), .rst_b(dev_rst_b),
        .frame_select_n(link.frame_select_n), .sclk(link.sclk),
        .serial_out_d(link.serial_out_d),
        .serial_out_oe(link.serial_out_oe));

    task automatic results;
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    task automatic timeout(string what);
        miscompares++;
        $display("Error %s exp 1 got 0", what);
        results();
    endtask : timeout

    task automatic chk_bit(string name, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s exp %b got %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(string name, logic [11:0] exp, logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s exp %h got %h", name, exp, got);
        end
    endtask : chk_word

    // One frame request, held until taken, then wait for idle
    task automatic frame(logic [4:0] edges, logic [11:0] smp);
        int n;
        @(negedge clk);
        cmd_edges = edges;
        sample_in = smp;
        cmd_valid = 1'b1;
        for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge clk);
        if (n == 400) timeout("cmd_ready");
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (2) @(negedge clk);
        chk_bit("analog_on", 1'b1, analog_on);
        // Line undefined while the device is still held in reset
        if (dev_rst_b) begin
            chk_bit("line", 1'b0, link.serial_out_line);
        end
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge clk);
        if (n == 400) timeout("idle");
        chk_bit("serial_out_oe", 1'b0, link.serial_out_oe);
    endtask : frame

    task automatic read_word(logic [11:0] exp);
        int n;
        for (n = 0; n < 50 && word_valid !== 1'b1; n++) @(negedge clk);
        if (n == 50) timeout("word_valid");
        chk_word("word_data", exp, word_data);
        word_ready = 1'b1;
        @(negedge clk);
        word_ready = 1'b0;
        @(negedge clk);
    endtask : read_word

    initial begin
        int i;
        logic [11:0] smp;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        // Device reset spans one short frame so its edges see it
        frame(5'h02, 12'h000);
        dev_rst_b = 1'b1;
        chk_bit("shutdown_mode", 1'b0, shutdown_mode);
        chk_bit("frame_dummy", 1'b1, frame_dummy);
        for (i = 0; i < 12; i++) begin
            smp = 12'hA5C ^ 12'(i * 273);
            frame(t_edges[i], smp);
            chk_bit("shutdown_mode", sd_mask[i], shutdown_mode);
            chk_bit("analog_on", !sd_mask[i], analog_on);
            chk_bit("frame_dummy", dm_mask[i], frame_dummy);
            if (t_edges[i] >= 5'h10) begin
                chk_bit("powered_up", 1'b1, powered_up);
            end
            if (rd_mask[i]) begin
                read_word(smp);
            end else if (keep_mask[i]) begin
                pend.push_back(smp);
            end else begin
                chk_bit("word_valid", 1'b0, word_valid);
            end
            $display("Test %0d done, edges %0d", i, t_edges[i]);
        end
        chk_bit("cmd_ready", 1'b0, cmd_ready);
        while (pend.size() > 0) read_word(pend.pop_front());
        // Frame closed before any serial edge, then a full frame
        frame(5'h00, 12'h3C6);
        chk_bit("shutdown_mode", 1'b0, shutdown_mode);
        chk_bit("word_valid", 1'b0, word_valid);
        frame(5'h10, 12'h5A9);
        chk_bit("frame_dummy", 1'b0, frame_dummy);
        read_word(12'h5A9);
        $display("Test restart done, edges 0 then 16");
        chk_bit("word_valid", 1'b0, word_valid);
        results();
    end
endmodule : tb_top
`default_nettype wire
